// File: core/general_call_status.sv
// Sticky general-call status flag with disable and read-to-clear
`timescale 1ns/1ps
module general_call_status
    import scl_timing_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clock_enable,
    input wire logic i_controller_enable,
    input wire logic i_general_call_acked,
    input wire logic i_general_call_clear,
    output logic o_general_call_flag
);

    typedef struct packed {
        logic flag;
    } gc_state_t;

    gc_state_t state;
    gc_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (!i_controller_enable)
        begin
            next_state.flag = 1'b0;
        end
        else if (i_general_call_acked)
        begin
            // Set beats a clear in the same cycle so no general call is lost
            next_state.flag = 1'b1;
        end
        else if (i_general_call_clear)
        begin
            next_state.flag = 1'b0;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            state <= '0;
        end
        else if (i_clock_enable)
        begin
            state <= next_state;
        end
    end

    assign o_general_call_flag = state.flag;

endmodule : general_call_status

// File: core/i2c_scl_timing_gencall.sv
// SCL phase-count registers, speed selection and general-call status of the two-wire controller
`timescale 1ns/1ps
module i2c_scl_timing_gencall
    import scl_timing_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clock_enable,
    input wire logic i_controller_enable,
    input wire logic [31:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [31:0] o_reg_rdata,
    input wire logic i_scl_run,
    input wire logic [1:0] i_speed,
    input wire logic i_hs_preamble,
    input wire logic [15:0] i_hs_high_count,
    input wire logic [15:0] i_hs_low_count,
    input wire logic i_scl,
    output logic o_scl_out,
    output logic o_scl_oe_n,
    output logic o_scl_busy,
    input wire logic i_general_call_acked,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_rx_push,
    output logic [7:0] o_rx_data,
    output logic o_general_call_flag
);

    typedef struct packed {
        logic [15:0] std_high_count;
        logic [15:0] std_low_count;
        logic [15:0] fast_high_count;
        logic [15:0] fast_low_count;
        logic [31:0] read_data;
        logic rx_push;
        logic [7:0] rx_data;
    } top_state_t;

    // Which register a bus address selects
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_STD_HIGH = 3'h1,
        SEL_STD_LOW = 3'h2,
        SEL_FAST_HIGH = 3'h3,
        SEL_FAST_LOW = 3'h4,
        SEL_STATUS = 3'h5,
        SEL_GC_CLEAR = 3'h6
    } reg_sel_t;

    // Shared by the write path, the read mux and the clear strobe
    function automatic reg_sel_t decode_reg(input logic [31:0] addr);
        unique case (addr)
            ADDR_STD_HIGH_COUNT:
            begin
                decode_reg = SEL_STD_HIGH;
            end
            ADDR_STD_LOW_COUNT:
            begin
                decode_reg = SEL_STD_LOW;
            end
            ADDR_FAST_HIGH_COUNT:
            begin
                decode_reg = SEL_FAST_HIGH;
            end
            ADDR_FAST_LOW_COUNT:
            begin
                decode_reg = SEL_FAST_LOW;
            end
            ADDR_MASKED_INTR_STATUS:
            begin
                decode_reg = SEL_STATUS;
            end
            ADDR_GENERAL_CALL_CLEAR:
            begin
                decode_reg = SEL_GC_CLEAR;
            end
            default:
            begin
                decode_reg = SEL_NONE;
            end
        endcase
    endfunction : decode_reg

    top_state_t state;
    top_state_t next_state;

    logic general_call_flag;
    logic general_call_clear;
    logic count_write_open;
    logic [15:0] phase_high_count;
    logic [15:0] phase_low_count;
    speed_t speed;
    reg_sel_t reg_sel;
    logic [15:0] count_wdata;
    logic [31:0] read_word;

    // Counts are locked while enabled; writes open at disable, even while a period begun earlier still runs
    assign count_write_open = !i_controller_enable;

    // Upper write-data bits are dropped; the counts are 16 bits wide
    assign count_wdata = i_reg_wdata[COUNT_MSB:0];

    // One address decode for writes, reads and the clear strobe
    assign reg_sel = decode_reg(i_reg_addr);

    // Reading the clear register consumes the flag
    assign general_call_clear = i_reg_read && (reg_sel == SEL_GC_CLEAR);

    assign speed = speed_t'(i_speed);

    // Phase counts for the selected speed
    // The timer samples them at each phase start, so a speed change waits a phase
    always_comb
    begin
        phase_high_count = state.std_high_count;
        phase_low_count = state.std_low_count;
        unique case (speed)
            SPEED_STD:
            begin
                phase_high_count = state.std_high_count;
                phase_low_count = state.std_low_count;
            end
            SPEED_FAST:
            begin
                phase_high_count = state.fast_high_count;
                phase_low_count = state.fast_low_count;
            end
            SPEED_HIGH:
            begin
                if (i_hs_preamble)
                begin
                    // Master code, start byte and general call go at fast timing
                    phase_high_count = state.fast_high_count;
                    phase_low_count = state.fast_low_count;
                end
                else
                begin
                    phase_high_count = i_hs_high_count;
                    phase_low_count = i_hs_low_count;
                end
            end
            default:
            begin
                phase_high_count = state.std_high_count;
                phase_low_count = state.std_low_count;
            end
        endcase
    end

    // Read mux; the status word shows only the general-call bit, the rest read zero
    always_comb
    begin
        read_word = READ_ZERO;
        unique case (reg_sel)
            SEL_STD_HIGH:
            begin
                read_word[COUNT_MSB:0] = state.std_high_count;
            end
            SEL_STD_LOW:
            begin
                read_word[COUNT_MSB:0] = state.std_low_count;
            end
            SEL_FAST_HIGH:
            begin
                read_word[COUNT_MSB:0] = state.fast_high_count;
            end
            SEL_FAST_LOW:
            begin
                read_word[COUNT_MSB:0] = state.fast_low_count;
            end
            SEL_STATUS:
            begin
                read_word[GC_FLAG_BIT] = general_call_flag;
            end
            SEL_GC_CLEAR:
            begin
                read_word[GC_CLEAR_BIT] = general_call_flag;
            end
            default:
            begin
            end
        endcase
    end

    always_comb
    begin
        next_state = state;

        // Register writes, clamped to their floors
        if (i_reg_write && count_write_open)
        begin
            unique case (reg_sel)
                SEL_STD_HIGH:
                begin
                    next_state.std_high_count =
                        clamp_count(count_wdata, MIN_HIGH_COUNT);
                end
                SEL_STD_LOW:
                begin
                    next_state.std_low_count =
                        clamp_count(count_wdata, MIN_LOW_COUNT);
                end
                SEL_FAST_HIGH:
                begin
                    next_state.fast_high_count =
                        clamp_count(count_wdata, MIN_HIGH_COUNT);
                end
                SEL_FAST_LOW:
                begin
                    // Whole-word write, so byte ordering cannot tear the count
                    next_state.fast_low_count =
                        clamp_count(count_wdata, MIN_LOW_COUNT);
                end
                default:
                begin
                end
            endcase
        end

        // Read data, registered and held until the next read
        if (i_reg_read)
        begin
            next_state.read_data = read_word;
        end

        // Received bytes, general-call data included, go on to the receive buffer
        next_state.rx_push = i_rx_valid;
        if (i_rx_valid)
        begin
            next_state.rx_data = i_rx_data;
        end
    end

    // Clock enable low freezes every register; reset still acts
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            state.std_high_count <= RESET_STD_HIGH;
            state.std_low_count <= RESET_STD_LOW;
            state.fast_high_count <= RESET_FAST_HIGH;
            state.fast_low_count <= RESET_FAST_LOW;
            state.read_data <= READ_ZERO;
            state.rx_push <= 1'b0;
            state.rx_data <= BYTE_ZERO;
        end
        else if (i_clock_enable)
        begin
            state <= next_state;
        end
    end

    // SCL periods start only while the controller is enabled; one under way runs to its end
    scl_phase_timer u_scl_phase_timer (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_clock_enable(i_clock_enable),
        .i_run(i_scl_run && i_controller_enable),
        .i_scl(i_scl),
        .i_high_count(phase_high_count),
        .i_low_count(phase_low_count),
        .o_scl_out(o_scl_out),
        .o_scl_oe_n(o_scl_oe_n),
        .o_busy(o_scl_busy)
    );

    // Disable wins over an acknowledge in the same cycle
    general_call_status u_general_call_status (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_clock_enable(i_clock_enable),
        .i_controller_enable(i_controller_enable),
        .i_general_call_acked(i_general_call_acked),
        .i_general_call_clear(general_call_clear),
        .o_general_call_flag(general_call_flag)
    );

    assign o_reg_rdata = state.read_data;
    assign o_rx_push = state.rx_push;
    assign o_rx_data = state.rx_data;
    assign o_general_call_flag = general_call_flag;

endmodule : i2c_scl_timing_gencall

// File: core/scl_phase_timer.sv
// SCL low/high phase timer driving the open-drain clock pin
`timescale 1ns/1ps
module scl_phase_timer
    import scl_timing_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clock_enable,
    input wire logic i_run,
    input wire logic i_scl,
    input wire logic [15:0] i_high_count,
    input wire logic [15:0] i_low_count,
    output logic o_scl_out,
    output logic o_scl_oe_n,
    output logic o_busy
);

    typedef struct packed {
        phase_t phase;
        logic [15:0] count;
        logic scl_oe_n;
        logic busy;
        logic scl_out;
    } timer_state_t;

    timer_state_t state;
    timer_state_t next_state;

    always_comb
    begin
        next_state = state;
        unique case (state.phase)
            PHASE_IDLE:
            begin
                if (i_run)
                begin
                    next_state.phase = PHASE_LOW;
                    next_state.count = i_low_count;
                end
            end
            PHASE_LOW:
            begin
                if (state.count == PHASE_LAST)
                begin
                    next_state.phase = PHASE_HIGH;
                    next_state.count = i_high_count;
                end
                else
                begin
                    next_state.count = state.count - COUNT_STEP;
                end
            end
            PHASE_HIGH:
            begin
                // Hold while another device stretches SCL low
                if (i_scl)
                begin
                    if (state.count == PHASE_LAST)
                    begin
                        next_state.phase = i_run ? PHASE_LOW : PHASE_IDLE;
                        next_state.count = i_low_count;
                    end
                    else
                    begin
                        next_state.count = state.count - COUNT_STEP;
                    end
                end
            end
            default:
            begin
                next_state.phase = PHASE_IDLE;
            end
        endcase
        // Enable is active low: pin pulled low only in the low phase
        next_state.scl_oe_n = (next_state.phase != PHASE_LOW);
        next_state.busy = (next_state.phase != PHASE_IDLE);
        // Open-drain: the driven level is always low
        next_state.scl_out = 1'b0;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            state.phase <= PHASE_IDLE;
            state.count <= '0;
            state.scl_oe_n <= 1'b1;
            state.busy <= 1'b0;
            state.scl_out <= 1'b0;
        end
        else if (i_clock_enable)
        begin
            state <= next_state;
        end
    end

    assign o_scl_out = state.scl_out;
    assign o_scl_oe_n = state.scl_oe_n;
    assign o_busy = state.busy;

endmodule : scl_phase_timer

// File: shared/scl_timing_pkg.sv
// Package: register map, reset values, minima and shared types for the SCL timing block
package scl_timing_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_STD_HIGH_COUNT = 32'h5000_1314;
    localparam logic [31:0] ADDR_STD_LOW_COUNT = 32'h5000_1318;
    localparam logic [31:0] ADDR_FAST_HIGH_COUNT = 32'h5000_131C;
    localparam logic [31:0] ADDR_FAST_LOW_COUNT = 32'h5000_1320;
    localparam logic [31:0] ADDR_MASKED_INTR_STATUS = 32'h5000_132C;
    localparam logic [31:0] ADDR_GENERAL_CALL_CLEAR = 32'h5000_1368;

    // Reset values of the phase counts
    localparam logic [15:0] RESET_STD_HIGH = 16'h0048;
    localparam logic [15:0] RESET_STD_LOW = 16'h004F;
    localparam logic [15:0] RESET_FAST_HIGH = 16'h0008;
    localparam logic [15:0] RESET_FAST_LOW = 16'h0017;

    // Smallest values a phase count may hold
    localparam logic [15:0] MIN_HIGH_COUNT = 16'h0006;
    localparam logic [15:0] MIN_LOW_COUNT = 16'h0008;

    // Field positions
    localparam int COUNT_MSB = 15;
    localparam int GC_FLAG_BIT = 11;
    localparam int GC_CLEAR_BIT = 0;

    localparam logic [15:0] PHASE_LAST = 16'h0001;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        SPEED_STD = 2'h1,
        SPEED_FAST = 2'h2,
        SPEED_HIGH = 2'h3
    } speed_t;

    typedef enum logic [2:0] {
        PHASE_IDLE = 3'h1,
        PHASE_LOW = 3'h2,
        PHASE_HIGH = 3'h4
    } phase_t;

    // Raise a written count to its floor
    function automatic logic [15:0] clamp_count(
        input logic [15:0] value,
        input logic [15:0] floor
    );
        clamp_count = (value < floor) ? floor : value;
    endfunction : clamp_count

endpackage : scl_timing_pkg

// File: testbench/i2c_scl_timing_gencall_bench.sv
// Self-checking bench for the SCL timing and general-call block
`timescale 1ns/1ps
module i2c_scl_timing_gencall_bench;
    import scl_timing_pkg::*;
    logic i_clock, i_srst, i_controller_enable, i_reg_write, i_reg_read, i_scl_run;
    logic i_hs_preamble, i_general_call_acked, i_rx_valid, o_rx_push, o_general_call_flag;
    logic o_scl_out, o_scl_oe_n, o_scl_busy, scl_line;
    logic [31:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [1:0] i_speed;
    logic [7:0] i_rx_data, o_rx_data;
    logic [3:0] stretch;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    int lo, hi;
    logic [31:0] cnt_addr [4] = '{ADDR_STD_HIGH_COUNT, ADDR_STD_LOW_COUNT,
        ADDR_FAST_HIGH_COUNT, ADDR_FAST_LOW_COUNT};
    logic [31:0] rst_val [4] = '{32'h48, 32'h4F, 32'h8, 32'h17};
    logic [31:0] floor_val [4] = '{32'h6, 32'h8, 32'h6, 32'h8};
    logic [31:0] prog_val [4] = '{32'h7, 32'hA, 32'h9, 32'hC};

    i2c_scl_timing_gencall u_dut (.i_clock, .i_srst, .i_clock_enable(1'b1),
        .i_controller_enable, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read,
        .o_reg_rdata, .i_scl_run, .i_speed, .i_hs_preamble, .i_hs_high_count(16'h000D),
        .i_hs_low_count(16'h0010), .i_scl(scl_line), .o_scl_out, .o_scl_oe_n,
        .o_scl_busy(o_scl_busy), .i_general_call_acked, .i_rx_valid, .i_rx_data,
        .o_rx_push, .o_rx_data, .o_general_call_flag);
    scl_line_model u_line (.i_clock, .i_scl_out(o_scl_out), .i_scl_oe_n(o_scl_oe_n),
        .i_stretch(stretch), .o_scl(scl_line));

    initial
    begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // Ceiling well above the few hundred cycles the run needs
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_wr(input logic [31:0] addr, input logic [31:0] data);
        @(posedge i_clock);
        i_reg_write <= 1'b1;
        i_reg_addr <= addr;
        i_reg_wdata <= data;
        @(posedge i_clock);
        i_reg_write <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input string what, input logic [31:0] addr, input logic [31:0] exp);
        @(posedge i_clock);
        i_reg_read <= 1'b1;
        i_reg_addr <= addr;
        @(posedge i_clock);
        i_reg_read <= 1'b0;
        #1 check(what, o_reg_rdata, exp);
    endtask : reg_rd

    task automatic set_enable(input logic en);
        @(posedge i_clock);
        i_controller_enable <= en;
    endtask : set_enable

    task automatic pulse_ack;
        @(posedge i_clock);
        i_general_call_acked <= 1'b1;
        @(posedge i_clock);
        i_general_call_acked <= 1'b0;
        #1;
    endtask : pulse_ack

    // One SCL period; high cycles count only while the line is really high
    task automatic scl_period(input logic [1:0] spd, input logic pre);
        int n;
        n = 0;
        lo = 0;
        hi = 0;
        @(posedge i_clock);
        i_speed <= spd;
        i_hs_preamble <= pre;
        i_scl_run <= 1'b1;
        @(posedge i_clock);
        i_scl_run <= 1'b0;
        #1;
        while (o_scl_busy === 1'b1 && n < 500)
        begin
            if (o_scl_oe_n === 1'b0)
                lo++;
            else if (scl_line === 1'b1)
                hi++;
            n++;
            @(posedge i_clock);
            #1;
        end
    endtask : scl_period

    task automatic t_counts;
        for (int k = 0; k < 4; k++)
            reg_rd("count reset", cnt_addr[k], rst_val[k]);
        reg_rd("status reset", ADDR_MASKED_INTR_STATUS, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            reg_wr(cnt_addr[k], floor_val[k] - 32'h1);
            reg_rd("below floor", cnt_addr[k], floor_val[k]);
            reg_wr(cnt_addr[k], 32'hA5A5_0000 | floor_val[k]);
            reg_rd("at floor", cnt_addr[k], floor_val[k]);
            reg_wr(cnt_addr[k], prog_val[k]);
        end
        reg_wr(32'h5000_13F0, 32'h1234);
        reg_rd("unmapped", 32'h5000_13F0, 32'h0);
        set_enable(1'b1);
        for (int k = 0; k < 4; k++)
        begin
            reg_wr(cnt_addr[k], 32'h0100);
            reg_rd("locked", cnt_addr[k], prog_val[k]);
        end
    endtask : t_counts

    task automatic t_scl;
        stretch <= 4'h3;
        scl_period(SPEED_STD, 1'b0);
        check("std low", 32'(lo), prog_val[1]);
        check("std high", 32'(hi), prog_val[0]);
        stretch <= 4'h0;
        scl_period(SPEED_FAST, 1'b0);
        check("fast low", 32'(lo), prog_val[3]);
        check("fast high", 32'(hi), prog_val[2]);
        scl_period(SPEED_HIGH, 1'b1);
        check("hs pre low", 32'(lo), prog_val[3]);
        check("hs pre high", 32'(hi), prog_val[2]);
        check("scl drive", o_scl_out, 32'h0);
        scl_period(SPEED_HIGH, 1'b0);
        check("hs data low", 32'(lo), 32'h10);
        check("hs data high", 32'(hi), 32'hD);
        scl_period(2'h0, 1'b0);
        check("spd0 low", 32'(lo), prog_val[1]);
        check("spd0 high", 32'(hi), prog_val[0]);
    endtask : t_scl

    task automatic t_gencall;
        pulse_ack();
        check("flag set", o_general_call_flag, 32'h1);
        reg_rd("status", ADDR_MASKED_INTR_STATUS, 32'h0800);
        reg_rd("clear read", ADDR_GENERAL_CALL_CLEAR, 32'h1);
        check("flag cleared", o_general_call_flag, 32'h0);
        pulse_ack();
        set_enable(1'b0);
        @(posedge i_clock);
        #1 check("flag on disable", o_general_call_flag, 32'h0);
        pulse_ack();
        check("ack disabled", o_general_call_flag, 32'h0);
    endtask : t_gencall

    task automatic t_rx;
        @(posedge i_clock);
        i_rx_valid <= 1'b1;
        i_rx_data <= 8'hA5;
        @(posedge i_clock);
        i_rx_data <= 8'h3C;
        #1 check("rx first", {o_rx_push, o_rx_data}, 32'h1A5);
        @(posedge i_clock);
        i_rx_valid <= 1'b0;
        #1 check("rx second", {o_rx_push, o_rx_data}, 32'h13C);
    endtask : t_rx

    initial
    begin
        {i_srst, i_controller_enable, i_reg_write, i_reg_read, i_scl_run} = 5'h10;
        {i_hs_preamble, i_general_call_acked, i_rx_valid} = 3'h0;
        {i_reg_addr, i_reg_wdata, i_speed, i_rx_data, stretch} = 78'h0;
        repeat (8) @(posedge i_clock);
        i_srst <= 1'b0;
        t_counts();
        t_scl();
        t_gencall();
        t_rx();
        print_verdict();
    end
endmodule : i2c_scl_timing_gencall_bench

// File: testbench/i2c_scl_timing_gencall_chk.sv
// Port assertions for the SCL timing and general-call block
`timescale 1ns/1ps
module i2c_scl_timing_gencall_chk
    import scl_timing_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clock_enable,
    input wire logic i_controller_enable,
    input wire logic [31:0] i_reg_addr,
    input wire logic i_reg_read,
    input wire logic i_scl_run,
    input wire logic o_scl_oe_n,
    input wire logic o_scl_busy,
    input wire logic i_general_call_acked,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic o_rx_push,
    input wire logic [7:0] o_rx_data,
    input wire logic o_general_call_flag
);
    logic clr_rd;
    assign clr_rd = i_reg_read && (i_reg_addr == ADDR_GENERAL_CALL_CLEAR);

    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    a_flag_set: assert property (
        i_general_call_acked && i_controller_enable && i_clock_enable |=> o_general_call_flag)
        else $error("flag not set after ack");
    a_flag_cause: assert property (
        $rose(o_general_call_flag) |-> $past(i_general_call_acked))
        else $error("flag rose without ack");
    a_flag_disable: assert property (
        !i_controller_enable && i_clock_enable |=> !o_general_call_flag)
        else $error("flag survived disable");
    a_flag_read_clear: assert property (
        clr_rd && i_clock_enable && !i_general_call_acked |=> !o_general_call_flag)
        else $error("flag survived clear read");
    a_flag_hold: assert property (
        o_general_call_flag && i_controller_enable && !clr_rd |=> o_general_call_flag)
        else $error("flag dropped on its own");
    a_rx_copy: assert property (
        i_rx_valid && i_clock_enable |=> o_rx_push && (o_rx_data == $past(i_rx_data)))
        else $error("received byte not forwarded");
    a_rx_quiet: assert property (
        !i_rx_valid && i_clock_enable |=> !o_rx_push)
        else $error("spurious receive push");
    a_low_floor: assert property (
        $fell(o_scl_oe_n) |-> !o_scl_oe_n [*8])
        else $error("low phase shorter than floor");
    a_high_floor: assert property (
        $rose(o_scl_oe_n) && o_scl_busy |-> o_scl_oe_n [*6])
        else $error("high phase shorter than floor");
    a_idle_release: assert property (
        !o_scl_busy |-> o_scl_oe_n)
        else $error("clock pulled while idle");
    a_run_start: assert property (
        i_scl_run && i_controller_enable && i_clock_enable && !o_scl_busy |=> !o_scl_oe_n)
        else $error("low phase did not start");

    c_flag: cover property (i_general_call_acked && i_controller_enable);
    c_clear: cover property (clr_rd && o_general_call_flag);
    c_period: cover property ($rose(o_scl_oe_n) && o_scl_busy);
endmodule : i2c_scl_timing_gencall_chk

bind i2c_scl_timing_gencall i2c_scl_timing_gencall_chk u_chk (.i_clock, .i_srst,
    .i_clock_enable, .i_controller_enable, .i_reg_addr, .i_reg_read, .i_scl_run,
    .o_scl_oe_n, .o_scl_busy, .i_general_call_acked, .i_rx_valid, .i_rx_data,
    .o_rx_push, .o_rx_data, .o_general_call_flag);

// File: testbench/scl_line_model.sv
// Open-drain SCL line with pull-up and a far-side device that stretches the clock
`timescale 1ns/1ps
module scl_line_model
(
    input wire logic i_clock,
    input wire logic i_scl_out,
    input wire logic i_scl_oe_n,
    input wire logic [3:0] i_stretch,
    output logic o_scl
);
    logic oe_n_q = 1'b1;
    logic [3:0] hold_cnt = 4'h0;
    logic first;
    // Stretch starts in the very cycle the block lets go
    assign first = i_scl_oe_n && !oe_n_q && (i_stretch != 4'h0);
    always @(posedge i_clock)
    begin
        oe_n_q <= i_scl_oe_n;
        if (first)
            hold_cnt <= i_stretch - 4'h1;
        else if (hold_cnt != 4'h0)
            hold_cnt <= hold_cnt - 4'h1;
    end
    // Pull-up wins only when nobody pulls low
    assign o_scl = !i_scl_oe_n ? i_scl_out : !(first || hold_cnt != 4'h0);
endmodule : scl_line_model
